// file: hdl/iocs_decode.sv
// I/O chip select decoder with bus placement and fast video timing
module iocs_decode (
  // Clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_n,
  // Host I/O cycle
  input  wire logic                          i_io_strobe,
  input  wire logic                          i_io_write,
  input  wire logic                          i_io_byte,
  input  wire logic [iocs_pkg::ADDR_W-1:0]   i_io_addr,
  input  wire logic [iocs_pkg::DATA_W-1:0]   i_io_wdata,
  // Register read answer
  output logic      [iocs_pkg::DATA_W-1:0]   o_io_rdata,
  output logic                               o_io_rvalid,
  // Chip select
  output logic                               o_cs_valid,
  output logic      [iocs_pkg::CS_W-1:0]     o_cs_num,
  output logic                               o_cs_expansion,
  output logic                               o_video_one_wait
);
  import iocs_pkg::*;

  // Serial range match shared by both serial ports
  function automatic logic com_hit(input logic [2:0] code, input logic [LOC_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (code)
      COM_CODE_3F8: hit = (a[LOC_W-1:COM_SPAN] == COM_3F8[LOC_W-1:COM_SPAN]);
      COM_CODE_2F8: hit = (a[LOC_W-1:COM_SPAN] == COM_2F8[LOC_W-1:COM_SPAN]);
      COM_CODE_3E8: hit = (a[LOC_W-1:COM_SPAN] == COM_3E8[LOC_W-1:COM_SPAN]);
      COM_CODE_2E8: hit = (a[LOC_W-1:COM_SPAN] == COM_2E8[LOC_W-1:COM_SPAN]);
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Address bits that take part in the programmable compare
  function automatic logic [ADDR_W-1:0] pcs_care(input logic umsk, input logic [2:0] lmsk);
    logic [ADDR_W-1:0] m;
    logic [2:0]        ign;
    m   = '1;
    ign = (lmsk > 3'(PCS_LMSK_MAX)) ? 3'h0 : lmsk;
    if (!umsk) begin
      m[ADDR_W-1:LOC_W] = '0;
    end
    for (int i = 0; i < PCS_LMSK_MAX; i++) begin
      if (i < int'(ign)) begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction

  logic [DATA_W-1:0] port_sel;
  logic [DATA_W-1:0] disk_rtc;
  logic [DATA_W-1:0] pcs_addr;

  logic [CS_W-1:0]   next_cs_num;
  logic              next_cs_exp;

  // Configuration port hits
  wire hit_port_sel = (i_io_addr == IO_PORT_SEL);
  wire hit_disk_rtc = (i_io_addr == IO_DISK_RTC);
  wire hit_pcs_addr = (i_io_addr == IO_PCS_ADDR);
  wire cfg_hit      = hit_port_sel | hit_disk_rtc | hit_pcs_addr;
  wire cfg_wr       = i_io_strobe & i_io_write;

  // Configuration fields
  wire [1:0] prn_code = port_sel[PRN_DEC_HI:PRN_DEC_LO];
  wire [2:0] coma_code = port_sel[COMA_HI:COMA_LO];
  wire [2:0] comb_code = port_sel[COMB_HI:COMB_LO];
  wire [2:0] pcs_lmsk = disk_rtc[PCS_LMSK_HI:PCS_LMSK_LO];

  // Low address bits; upper bits ignored for fixed ranges
  wire [LOC_W-1:0] a10 = i_io_addr[LOC_W-1:0];

  // Printer range decode
  wire prn_hit_3bc = (prn_code == PRN_CODE_3BC) &&
                     (a10[LOC_W-1:PRN_SPAN_SHORT] == PRN_3BC[LOC_W-1:PRN_SPAN_SHORT]);
  wire prn_hit_378 = (prn_code == PRN_CODE_378) &&
                     (a10[LOC_W-1:COM_SPAN] == PRN_378[LOC_W-1:COM_SPAN]);
  wire prn_hit_278 = (prn_code == PRN_CODE_278) &&
                     (a10[LOC_W-1:COM_SPAN] == PRN_278[LOC_W-1:COM_SPAN]);
  wire prn_hit     = prn_hit_3bc | prn_hit_378 | prn_hit_278;

  // Serial range decode
  wire coma_hit = com_hit(coma_code, a10);
  wire comb_hit = com_hit(comb_code, a10);

  // Clock chip strobes
  wire rtc_idx_hit = (a10 == RTC_IDX);
  wire rtc_dat_hit = (a10 == RTC_DAT);
  wire rtc_hit     = rtc_idx_hit | rtc_dat_hit;

  // Programmable select compare
  wire [ADDR_W-1:0] pcs_mask = pcs_care(disk_rtc[PCS_UMSK], pcs_lmsk);
  wire pcs_hit = disk_rtc[PCS_EN] && (((i_io_addr ^ pcs_addr) & pcs_mask) == '0);

  // Video ports shortened by the fast timing bit
  wire vid_port = (a10[LOC_W-1:VID_SPAN] == VID_3C0[LOC_W-1:VID_SPAN]) ||
                  (a10[LOC_W-1:VID_SPAN] == VID_3C4[LOC_W-1:VID_SPAN]) ||
                  (a10[LOC_W-1:VID_SPAN] == VID_3CE[LOC_W-1:VID_SPAN]);
  wire next_one_wait = i_io_strobe & i_io_byte & vid_port & disk_rtc[VID_FAST];

  // Any select; a same-range clash between serial ports favours port A
  wire dev_hit   = prn_hit | coma_hit | comb_hit | rtc_hit | pcs_hit;
  wire next_cs   = i_io_strobe & ~cfg_hit & dev_hit;
  wire rd_access = i_io_strobe & ~i_io_write & cfg_hit;

  // Select number and bus location by priority
  always_comb begin
    next_cs_num = CS_PCS;
    next_cs_exp = disk_rtc[PCS_LOC];
    if (prn_hit) begin
      next_cs_num = CS_PRN;
      next_cs_exp = port_sel[PRN_LOC];
    end else if (coma_hit) begin
      next_cs_num = CS_COM_A;
      next_cs_exp = port_sel[COMA_LOC];
    end else if (comb_hit) begin
      next_cs_num = CS_COM_B;
      next_cs_exp = port_sel[COMB_LOC];
    end else if (rtc_hit) begin
      next_cs_exp = disk_rtc[RTC_LOC];
      if (rtc_idx_hit) begin
        next_cs_num = CS_RTC_ALE;
      end else if (i_io_write) begin
        next_cs_num = CS_RTC_WR;
      end else begin
        next_cs_num = CS_RTC_RD;
      end
    end
  end

  // Read data of the addressed register
  wire [DATA_W-1:0] next_rdata = hit_port_sel ? port_sel :
                                 hit_disk_rtc ? disk_rtc :
                                 hit_pcs_addr ? pcs_addr : '0;

  // Configuration registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_sel <= REG_RESET;
      disk_rtc <= REG_RESET;
      pcs_addr <= REG_RESET;
    end else begin
      if (cfg_wr && hit_port_sel) port_sel <= i_io_wdata;
      if (cfg_wr && hit_disk_rtc) disk_rtc <= i_io_wdata;
      if (cfg_wr && hit_pcs_addr) pcs_addr <= i_io_wdata;
    end
  end

  // Registered select and read answer
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cs_valid       <= 1'b0;
      o_cs_num         <= '0;
      o_cs_expansion   <= 1'b0;
      o_video_one_wait <= 1'b0;
      o_io_rvalid      <= 1'b0;
      o_io_rdata       <= '0;
    end else begin
      o_cs_valid       <= next_cs;
      o_cs_num         <= next_cs ? next_cs_num : '0;
      o_cs_expansion   <= next_cs & next_cs_exp;
      o_video_one_wait <= next_one_wait;
      o_io_rvalid      <= rd_access;
      o_io_rdata       <= rd_access ? next_rdata : '0;
    end
  end

  // Checks on the decoder
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  wire cyc = i_io_strobe & ~cfg_hit;

  a_prn_range_378: assert property (
    cyc && prn_code == 2'h2 && a10[LOC_W-1:COM_SPAN] == PRN_378[LOC_W-1:COM_SPAN]
    |=> o_cs_valid && o_cs_num == 5'h0F)
    else $error("printer 378H range missed");

  a_prn_off: assert property (
    cyc && prn_code == 2'h0 && !coma_hit && !comb_hit && !rtc_hit && !pcs_hit
    |=> !o_cs_valid)
    else $error("printer select while disabled");

  a_prn_location: assert property (
    cyc && prn_hit |=> o_cs_expansion == $past(port_sel[PRN_LOC]))
    else $error("printer bus location wrong");

  a_coma_number: assert property (
    cyc && !prn_hit && coma_code == 3'h3 && a10[LOC_W-1:COM_SPAN] == COM_3E8[LOC_W-1:COM_SPAN]
    |=> o_cs_valid && o_cs_num == 5'h0E)
    else $error("serial A 3E8H select wrong");

  a_coma_location: assert property (
    cyc && !prn_hit && coma_hit |=> o_cs_expansion == $past(port_sel[COMA_LOC]))
    else $error("serial A bus location wrong");

  a_comb_number: assert property (
    cyc && !prn_hit && !coma_hit && comb_code == 3'h4 &&
    a10[LOC_W-1:COM_SPAN] == COM_2E8[LOC_W-1:COM_SPAN]
    |=> o_cs_valid && o_cs_num == 5'h10)
    else $error("serial B 2E8H select wrong");

  a_comb_location: assert property (
    cyc && !prn_hit && !coma_hit && comb_hit |=> o_cs_expansion == $past(port_sel[COMB_LOC]))
    else $error("serial B bus location wrong");

  a_rtc_location: assert property (
    cyc && !prn_hit && !coma_hit && !comb_hit && rtc_hit
    |=> o_cs_valid && o_cs_expansion == $past(disk_rtc[RTC_LOC]))
    else $error("clock chip bus location wrong");

  a_pcs_select: assert property (
    cyc && disk_rtc[PCS_EN] && i_io_addr == pcs_addr && !prn_hit && !coma_hit && !comb_hit && !rtc_hit
    |=> o_cs_valid && o_cs_num == 5'h11)
    else $error("programmable select missed");

  a_video_fast: assert property (
    i_io_strobe && i_io_byte && disk_rtc[VID_FAST] && a10 == 10'h3CF |=> o_video_one_wait)
    else $error("fast video wait missing");

  a_video_normal: assert property (
    !disk_rtc[VID_FAST] |=> !o_video_one_wait)
    else $error("video shortened while fast bit clear");

  a_upper_ignored: assert property (
    cyc && prn_code == 2'h3 && i_io_addr[LOC_W-1:COM_SPAN] == PRN_278[LOC_W-1:COM_SPAN]
    |=> o_cs_valid && o_cs_num == 5'h0F)
    else $error("upper address bits not ignored");

  a_com_unused: assert property (
    cyc && !prn_hit && !rtc_hit && !pcs_hit && coma_code > 3'h4 && comb_code > 3'h4
    |=> !o_cs_valid)
    else $error("select from unused serial code");

  a_prn_range_3bc: assert property (
    cyc && prn_code == PRN_CODE_3BC && a10[LOC_W-1:PRN_SPAN_SHORT] == PRN_3BC[LOC_W-1:PRN_SPAN_SHORT]
    |=> o_cs_valid && o_cs_num == CS_PRN)
    else $error("printer 3BCH range missed");

  a_coma_range: assert property (
    cyc && !prn_hit && coma_code == COM_CODE_2F8 && a10[LOC_W-1:COM_SPAN] == COM_2F8[LOC_W-1:COM_SPAN]
    |=> o_cs_valid && o_cs_num == CS_COM_A)
    else $error("serial A 2F8H select wrong");

  a_comb_range: assert property (
    cyc && !prn_hit && !coma_hit && comb_code == COM_CODE_3F8 &&
    a10[LOC_W-1:COM_SPAN] == COM_3F8[LOC_W-1:COM_SPAN]
    |=> o_cs_valid && o_cs_num == CS_COM_B)
    else $error("serial B 3F8H select wrong");

  a_rtc_index: assert property (
    cyc && !prn_hit && !coma_hit && !comb_hit && rtc_idx_hit
    |=> o_cs_valid && o_cs_num == CS_RTC_ALE)
    else $error("clock chip index select wrong");

  a_rtc_strobe: assert property (
    cyc && !prn_hit && !coma_hit && !comb_hit && rtc_dat_hit
    |=> o_cs_valid && o_cs_num == ($past(i_io_write) ? CS_RTC_WR : CS_RTC_RD))
    else $error("clock chip data strobe wrong");

  a_pcs_location: assert property (
    cyc && pcs_hit && !prn_hit && !coma_hit && !comb_hit && !rtc_hit
    |=> o_cs_valid && o_cs_expansion == $past(disk_rtc[PCS_LOC]))
    else $error("programmable select bus location wrong");

  a_cfg_no_select: assert property (
    i_io_strobe && cfg_hit |=> !o_cs_valid && o_io_rvalid == !$past(i_io_write))
    else $error("configuration cycle made a select");

  a_reg_readback: assert property (
    i_io_strobe && !i_io_write && hit_port_sel |=> o_io_rvalid && o_io_rdata == $past(port_sel))
    else $error("port select register read back wrong");

  a_video_word: assert property (
    i_io_strobe && !i_io_byte |=> !o_video_one_wait)
    else $error("word cycle shortened");

  a_cs_quiet: assert property (
    !i_io_strobe |=> !o_cs_valid && o_cs_num == '0 && !o_cs_expansion && !o_io_rvalid)
    else $error("select without a host cycle");

  c_comb_select: cover property (o_cs_valid && o_cs_num == CS_COM_B);
  c_fast_video:  cover property (o_video_one_wait);
  c_pcs_select:  cover property (o_cs_valid && o_cs_num == CS_PCS);
  c_reg_read:    cover property (o_io_rvalid && o_io_rdata != '0);
  c_rtc_exp:     cover property (o_cs_valid && o_cs_expansion && o_cs_num == CS_RTC_RD);

endmodule

// file: hdl/iocs_pkg.sv
// Constants for the I/O chip select decoder
package iocs_pkg;

  // Widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CS_W   = 5;
  localparam int LOC_W  = 10;  // Low address bits that three-digit ranges compare

  // Configuration ports (all sixteen address bits compared)
  localparam logic [ADDR_W-1:0] IO_PORT_SEL = 16'h2072;
  localparam logic [ADDR_W-1:0] IO_DISK_RTC = 16'h2872;
  localparam logic [ADDR_W-1:0] IO_PCS_ADDR = 16'h3072;
  localparam logic [DATA_W-1:0] REG_RESET   = 16'h0000;

  // Fields of the port select register
  localparam int PRN_DEC_HI = 10;
  localparam int PRN_DEC_LO = 9;
  localparam int PRN_LOC    = 8;
  localparam int COMA_HI    = 7;
  localparam int COMA_LO    = 5;
  localparam int COMA_LOC   = 4;
  localparam int COMB_HI    = 3;
  localparam int COMB_LO    = 1;
  localparam int COMB_LOC   = 0;

  // Fields of the disk, clock and video register
  localparam int RTC_LOC      = 15;
  localparam int VID_FAST     = 14;
  localparam int PCS_EN       = 12;
  localparam int PCS_UMSK     = 11;
  localparam int PCS_LMSK_HI  = 10;
  localparam int PCS_LMSK_LO  = 8;
  localparam int PCS_LOC      = 7;
  localparam int PCS_LMSK_MAX = 4;

  // Decode codes
  localparam logic [1:0] PRN_CODE_3BC = 2'h1;
  localparam logic [1:0] PRN_CODE_378 = 2'h2;
  localparam logic [1:0] PRN_CODE_278 = 2'h3;
  localparam logic [2:0] COM_CODE_3F8 = 3'h1;
  localparam logic [2:0] COM_CODE_2F8 = 3'h2;
  localparam logic [2:0] COM_CODE_3E8 = 3'h3;
  localparam logic [2:0] COM_CODE_2E8 = 3'h4;

  // Port ranges
  localparam int PRN_SPAN_SHORT = 2;  // Four-byte range
  localparam int COM_SPAN       = 3;  // Eight-byte ranges
  localparam int VID_SPAN       = 1;  // Two-byte pairs
  localparam logic [LOC_W-1:0] PRN_3BC = 10'h3BC;
  localparam logic [LOC_W-1:0] PRN_378 = 10'h378;
  localparam logic [LOC_W-1:0] PRN_278 = 10'h278;
  localparam logic [LOC_W-1:0] COM_3F8 = 10'h3F8;
  localparam logic [LOC_W-1:0] COM_2F8 = 10'h2F8;
  localparam logic [LOC_W-1:0] COM_3E8 = 10'h3E8;
  localparam logic [LOC_W-1:0] COM_2E8 = 10'h2E8;
  localparam logic [LOC_W-1:0] RTC_IDX = 10'h070;
  localparam logic [LOC_W-1:0] RTC_DAT = 10'h071;
  localparam logic [LOC_W-1:0] VID_3C0 = 10'h3C0;
  localparam logic [LOC_W-1:0] VID_3C4 = 10'h3C4;
  localparam logic [LOC_W-1:0] VID_3CE = 10'h3CE;

  // Chip select numbers
  localparam logic [CS_W-1:0] CS_RTC_ALE = 5'h05;
  localparam logic [CS_W-1:0] CS_RTC_WR  = 5'h06;
  localparam logic [CS_W-1:0] CS_RTC_RD  = 5'h07;
  localparam logic [CS_W-1:0] CS_COM_A   = 5'h0E;
  localparam logic [CS_W-1:0] CS_PRN     = 5'h0F;
  localparam logic [CS_W-1:0] CS_COM_B   = 5'h10;
  localparam logic [CS_W-1:0] CS_PCS     = 5'h11;

endpackage

// file: testbench/iocs_periph_model.sv
// Peripheral-side model that tallies chip selects by the bus they land on
module iocs_periph_model (
  // Clock
  input  wire logic                      i_mclk,
  // Chip select from the decoder
  input  wire logic                      i_cs_valid,
  input  wire logic [iocs_pkg::CS_W-1:0] i_cs_num,
  input  wire logic                      i_cs_expansion,
  // Tallies
  output int                             o_n_local,
  output int                             o_n_exp
);
  timeunit 1ns;
  timeprecision 100ps;
  import iocs_pkg::*;
  initial begin
    o_n_local = 0;
    o_n_exp   = 0;
  end
  // A peripheral answers only on the bus it was placed on
  always @(posedge i_mclk) begin
    if (i_cs_valid === 1'b1 && i_cs_expansion === 1'b1) o_n_exp++;
    else if (i_cs_valid === 1'b1 && i_cs_num !== 5'h00) o_n_local++;
  end
endmodule

// file: testbench/test_io_chip_select_decode.sv
// Self-checking bench for the I/O chip select decoder
module test_io_chip_select_decode;
  timeunit 1ns;
  timeprecision 100ps;
  import iocs_pkg::*;
  typedef struct packed {logic rv; logic [15:0] rd; logic cv; logic [4:0] cn; logic ce; logic vw;} iocs_note_t;
  logic        i_mclk = 0, i_rst_n = 0, i_io_strobe = 0, i_io_write = 0, i_io_byte = 0, pend = 0;
  logic [15:0] i_io_addr = 16'h0000, i_io_wdata = 16'h0000, o_io_rdata, lfsr = 16'h727B, r;
  logic        o_io_rvalid, o_cs_valid, o_cs_expansion, o_video_one_wait;
  logic [4:0]  o_cs_num;
  logic [15:0] sh [3];
  logic [15:0] cfg [3] = '{IO_PORT_SEL, IO_DISK_RTC, IO_PCS_ADDR};
  logic [9:0]  com_ad [6] = '{10'h3F8, 10'h2FF, 10'h3EC, 10'h2E8, 10'h3F0, 10'h3BD};
  iocs_note_t  notes [$];
  iocs_note_t  cur;
  int          n_fail = 0, samples_checked = 0, exp_loc = 0, exp_exp = 0, n_loc, n_exp;

  iocs_decode dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_io_strobe(i_io_strobe), .i_io_write(i_io_write),
    .i_io_byte(i_io_byte), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .o_io_rvalid(o_io_rvalid), .o_cs_valid(o_cs_valid), .o_cs_num(o_cs_num), .o_cs_expansion(o_cs_expansion),
    .o_video_one_wait(o_video_one_wait));
  iocs_periph_model u_periph (.i_mclk(i_mclk), .i_cs_valid(o_cs_valid), .i_cs_num(o_cs_num),
    .i_cs_expansion(o_cs_expansion), .o_n_local(n_loc), .o_n_exp(n_exp));

  initial begin
    forever #2 i_mclk = ~i_mclk;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Serial range match shared by both ports; unused codes match nothing
  function automatic logic com_hit(input logic [2:0] c, input logic [9:0] a);
    case (c)
      3'h1: com_hit = a[9:3] == 7'h7F;
      3'h2: com_hit = a[9:3] == 7'h5F;
      3'h3: com_hit = a[9:3] == 7'h7D;
      3'h4: com_hit = a[9:3] == 7'h5D;
      default: com_hit = 1'b0;
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One host cycle; the expected answer is worked out from the shadow registers
  task automatic cyc(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
    iocs_note_t n;
    logic [9:0] l;
    int k;
    logic [15:0] pm;
    n = '0;
    l = a[9:0];
    pm = {{6{sh[1][11]}}, 10'h3FF};
    if (sh[1][10:8] <= 3'h4) pm = pm & ~((16'h0001 << sh[1][10:8]) - 16'h0001);
    k = (a == cfg[0]) ? 0 : (a == cfg[1]) ? 1 : (a == cfg[2]) ? 2 : 3;
    @(posedge i_mclk);
    #1;
    i_io_strobe = 1;
    i_io_write = w;
    i_io_byte = b;
    i_io_addr = a;
    i_io_wdata = d;
    if (k < 3) begin
      n.rv = !w;
      n.rd = w ? 16'h0000 : sh[k];
      if (w) sh[k] = d;
    end else begin
      n.vw = b && sh[1][14] && (l[9:1] inside {9'h1E0, 9'h1E2, 9'h1E7});
      n.cv = 1;
      if (sh[0][10:9] == 1 && l[9:2] == 8'hEF || sh[0][10:9] == 2 && l[9:3] == 7'h6F ||
          sh[0][10:9] == 3 && l[9:3] == 7'h4F) begin
        n.cn = CS_PRN;
        n.ce = sh[0][8];
      end else if (com_hit(sh[0][7:5], l)) begin
        n.cn = CS_COM_A;
        n.ce = sh[0][4];
      end else if (com_hit(sh[0][3:1], l)) begin
        n.cn = CS_COM_B;
        n.ce = sh[0][0];
      end else if (l[9:1] == 9'h038) begin
        n.cn = l[0] ? (w ? CS_RTC_WR : CS_RTC_RD) : CS_RTC_ALE;
        n.ce = sh[1][15];
      end else if (sh[1][12] && ((a ^ sh[2]) & pm) == 16'h0000) begin
        n.cn = CS_PCS;
        n.ce = sh[1][7];
      end else n.cv = 0;
      if (n.cv && n.ce) exp_exp++;
      else if (n.cv) exp_loc++;
    end
    notes.push_back(n);
  endtask

  // Byte cycle to a fixed port with random ignored upper bits
  task automatic hit(input logic w, input logic [9:0] base);
    r = rnd();
    cyc(w, 1, {r[15:10], base}, 16'h0000);
  endtask

  // Watcher: the note of a strobe is compared one cycle later
  always @(posedge i_mclk) begin
    if (pend) begin
      cur = notes.pop_front();
      check("rvalid", o_io_rvalid, cur.rv);
      check("rdata", o_io_rdata, cur.rd);
      check("cs_valid", o_cs_valid, cur.cv);
      check("cs_num", o_cs_num, cur.cn);
      check("expansion", o_cs_expansion, cur.ce);
      check("one_wait", o_video_one_wait, cur.vw);
    end else if (i_rst_n) check("idle", {o_cs_valid, o_io_rvalid, o_video_one_wait}, 3'h0);
    pend = i_io_strobe === 1'b1 && i_rst_n === 1'b1;
  end

  initial begin
    #100000;
    check("timeout", 1, 0);
    close_out();
  end

  initial begin
    sh = '{default: 16'h0000};
    repeat (4) @(posedge i_mclk);
    #1 i_rst_n = 1;
    for (int k = 0; k < 3; k++) cyc(0, 0, cfg[k], 16'h0000);
    hit(0, 10'h070);
    for (int p = 0; p < 4; p++) begin
      r = rnd();
      cyc(1, 0, cfg[0], {5'h00, p[1:0], r[0], 8'h00});
      foreach (com_ad[i]) hit(0, com_ad[i]);
      hit(0, 10'h37A);
      hit(1, 10'h27F);
    end
    // Only one serial field is set at a time, never both to one range
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      if (c < 8) cyc(1, 0, cfg[0], {8'h00, c[2:0], r[0], 4'h0});
      else cyc(1, 0, cfg[0], {12'h000, c[2:0], r[0]});
      foreach (com_ad[i]) hit(c[0], com_ad[i]);
      cyc(0, 0, cfg[0], 16'h0000);
    end
    // Fast video is set here as for a tolerant display controller
    for (int v = 0; v < 4; v++) begin
      cyc(1, 0, cfg[1], {v[1], v[0], 14'h0000});
      hit(1, 10'h071);
      hit(0, 10'h071);
      hit(0, 10'h3C1);
      hit(0, 10'h3CF);
      hit(1, 10'h3C2);
      cyc(0, 0, 16'h03C4, 16'h0000);
      cyc(0, 0, cfg[1], 16'h0000);
    end
    // Programmable select with random upper and low address bits
    for (int m = 0; m < 8; m++) begin
      r = rnd();
      cyc(1, 0, cfg[2], {r[15:10], 10'h2A5});
      cyc(1, 0, cfg[1], {4'h1, r[1], m[2:0], r[2], 7'h00});
      repeat (4) begin
        r = rnd();
        cyc(r[0], 1, sh[2] ^ {r[15:10] & {6{r[6]}}, 6'h00, r[4:1] & {4{r[5]}}}, 16'h0000);
      end
    end
    repeat (40) begin
      r = rnd();
      cyc(r[0], r[1], r[9:0] == 10'h072 ? r ^ 16'h0001 : r, rnd());
    end
    @(posedge i_mclk);
    #1 i_io_strobe = 0;
    repeat (3) @(posedge i_mclk);
    check("local count", n_loc, exp_loc);
    check("exp count", n_exp, exp_exp);
    close_out();
  end
endmodule
